// ===== core/itr_regs.sv
`timescale 1ns/1ns
module itr_regs
	import itr_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	// Bus slave
	input  wire logic        hsel,
	input  wire logic [11:2] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [3:0]  hprot,
	input  wire logic [31:0] hwdata,
	input  wire logic        hreadyin,
	output logic             hreadyout,
	output logic [1:0]       hresp,
	output logic [31:0]      hrdata,
	// Live signals from the interrupt core
	input  wire logic        request_internal,
	input  wire logic        fast_request_internal,
	input  wire logic        core_vector_valid,
	input  wire logic        core_ack_forward,
	input  wire logic [31:0] core_vector_out,
	// Interrupt source pins
	input  wire logic [31:0] raw_source,
	// Daisy chain
	input  wire logic [31:0] chain_vector_in,
	output logic [31:0]      chain_vector_to_core,
	output logic [31:0]      chain_vector_out,
	// Processor and chain outputs
	output logic             request_out_n,
	output logic             fast_request_out_n,
	output logic             vector_valid_out,
	output logic             ack_forward_out,
	// Mode levels to the core
	output logic             test_enable,
	output logic             sampling_enable
);

	// ==========================================================
	// Bus address phase capture
	logic        wr_pending;
	logic [11:0] wr_addr;
	logic        rd_take;
	logic        wr_take;
	logic [11:0] ph_addr;

	assign ph_addr = {haddr, 2'b00};
	assign rd_take = hsel && htrans[1] && hreadyin && !hwrite;
	assign wr_take = hsel && htrans[1] && hreadyin && hwrite;

	// Never stalls: every access ends in its first data phase
	assign hreadyout = 1'b1;
	assign hresp     = ITR_HRESP_OKAY;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_pending <= 1'b0;
			wr_addr    <= 12'h000;
		end
		else if (clk_en)
		begin
			wr_pending <= wr_take;
			wr_addr    <= ph_addr;
		end
	end

	logic wr_control;
	logic wr_vin;
	logic wr_outctl;
	logic wr_vout;
	logic wr_clear;

	assign wr_control = wr_pending && (wr_addr == ITR_OFS_TEST_CONTROL);
	assign wr_vin     = wr_pending && (wr_addr == ITR_OFS_VECTOR_INPUT);
	assign wr_outctl  = wr_pending && (wr_addr == ITR_OFS_OUTPUT_CTRL);
	assign wr_vout    = wr_pending && (wr_addr == ITR_OFS_VECTOR_OUTPUT);
	assign wr_clear   = wr_pending && (wr_addr == ITR_OFS_SAMPLED_CLEAR);

	// ==========================================================
	// Test control
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			test_enable     <= ITR_RST_TEST_CONTROL[ITR_BIT_TEST_ENABLE];
			sampling_enable <= ITR_RST_TEST_CONTROL[ITR_BIT_SAMPLING_ENABLE];
		end
		else if (clk_en && wr_control)
		begin
			test_enable     <= hwdata[ITR_BIT_TEST_ENABLE];
			sampling_enable <= hwdata[ITR_BIT_SAMPLING_ENABLE];
		end
	end

	// ==========================================================
	// Pin synchronisers
	logic [31:0] source_sync;
	logic [31:0] chain_in_sync;

	itr_sync2 #(.WIDTH(ITR_SOURCES)) u_source_sync
	(
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.async_in (raw_source),
		.sync_out (source_sync)
	);

	itr_sync2 #(.WIDTH(32)) u_chain_sync
	(
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.async_in (chain_vector_in),
		.sync_out (chain_in_sync)
	);

	// ==========================================================
	// Vector input override
	logic [31:0] vin_field;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			vin_field <= ITR_RST_WORD;
		else if (clk_en && wr_vin && test_enable)
			vin_field <= hwdata;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			chain_vector_to_core <= ITR_RST_WORD;
		else if (clk_en)
			chain_vector_to_core <= test_enable ? vin_field : chain_in_sync;
	end

	// ==========================================================
	// Output control override
	logic [3:0] outctl_field;
	logic [3:0] outctl_live;
	logic [3:0] outctl_sel;
	logic [3:0] outctl_sync;

	assign outctl_live = {core_ack_forward, core_vector_valid,
		request_internal, fast_request_internal};

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			outctl_field <= ITR_RST_OUTPUT_CTRL;
		else if (clk_en && wr_outctl && test_enable)
			outctl_field <= hwdata[ITR_BIT_ACK_FORWARD:ITR_BIT_FAST_REQUEST];
	end

	assign outctl_sel = test_enable ? outctl_field : outctl_live;

	// Readback is resynchronised, so it trails the field by two cycles
	itr_sync2 #(.WIDTH(ITR_OUT_BITS)) u_outctl_sync
	(
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.async_in (outctl_sel),
		.sync_out (outctl_sync)
	);

	// Registered pins; request lines are active low toward the processor
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ack_forward_out    <= 1'b0;
			vector_valid_out   <= 1'b0;
			request_out_n      <= 1'b1;
			fast_request_out_n <= 1'b1;
		end
		else if (clk_en)
		begin
			ack_forward_out    <= outctl_sel[3];
			vector_valid_out   <= outctl_sel[2];
			request_out_n      <= !outctl_sel[1];
			fast_request_out_n <= !outctl_sel[0];
		end
	end

	// ==========================================================
	// Vector output override
	logic [31:0] vout_field;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			vout_field <= ITR_RST_WORD;
		else if (clk_en && wr_vout && test_enable)
			vout_field <= hwdata;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			chain_vector_out <= ITR_RST_WORD;
		else if (clk_en)
			chain_vector_out <= test_enable ? vout_field : core_vector_out;
	end

	// ==========================================================
	// Sampled source status
	logic [31:0] sampled_bits;

	// Only local sources feed this; the chained request has no bit
	generate
		for (genvar i = 0; i < ITR_SOURCES; i++)
		begin : g_sample
			always_ff @(posedge sys_clk or negedge reset_n)
			begin
				if (!reset_n)
					sampled_bits[i] <= 1'b0;
				else if (clk_en)
				begin
					if (sampling_enable && source_sync[i])
						sampled_bits[i] <= 1'b1;
					else if (sampling_enable && wr_clear && hwdata[i])
						sampled_bits[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Read data, taken in the address phase
	logic [31:0] next_rdata;

	always_comb
	begin
		next_rdata = ITR_RST_WORD;
		case (ph_addr)
			ITR_OFS_TEST_CONTROL:
			begin
				next_rdata[ITR_BIT_TEST_ENABLE]     = test_enable;
				next_rdata[ITR_BIT_SAMPLING_ENABLE] = sampling_enable;
			end
			ITR_OFS_VECTOR_INPUT:
				next_rdata = test_enable ? vin_field : chain_in_sync;
			ITR_OFS_OUTPUT_CTRL:
				next_rdata[ITR_BIT_ACK_FORWARD:ITR_BIT_FAST_REQUEST] = outctl_sync;
			ITR_OFS_VECTOR_OUTPUT:
				next_rdata = test_enable ? vout_field : core_vector_out;
			ITR_OFS_SAMPLED:
				next_rdata = sampling_enable ? sampled_bits : ITR_RST_WORD;
			default:
				next_rdata = ITR_RST_WORD;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			hrdata <= ITR_RST_WORD;
		else if (clk_en && rd_take)
			hrdata <= next_rdata;
	end
endmodule

// ===== core/itr_sync2.sv
`timescale 1ns/1ns
module itr_sync2
	import itr_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stage_one <= '0;
			sync_out  <= '0;
		end
		else if (clk_en)
		begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end
endmodule

// ===== pkg/itr_pkg.sv
package itr_pkg;

	// ==========================================================
	// Register byte offsets within the block's 4 KB window
	localparam logic [11:0] ITR_OFS_TEST_CONTROL  = 12'h300;
	localparam logic [11:0] ITR_OFS_VECTOR_INPUT  = 12'h308;
	localparam logic [11:0] ITR_OFS_OUTPUT_CTRL   = 12'h30C;
	localparam logic [11:0] ITR_OFS_VECTOR_OUTPUT = 12'h310;
	localparam logic [11:0] ITR_OFS_SAMPLED       = 12'h314;
	localparam logic [11:0] ITR_OFS_SAMPLED_CLEAR = 12'h318;

	// ==========================================================
	// Field positions
	localparam int ITR_BIT_TEST_ENABLE     = 0;
	localparam int ITR_BIT_SAMPLING_ENABLE = 1;
	localparam int ITR_BIT_ACK_FORWARD     = 9;
	localparam int ITR_BIT_VECTOR_VALID    = 8;
	localparam int ITR_BIT_REQUEST         = 7;
	localparam int ITR_BIT_FAST_REQUEST    = 6;

	// ==========================================================
	// Widths and reset values
	localparam int          ITR_SOURCES          = 32;
	localparam int          ITR_OUT_BITS         = 4;
	localparam logic [1:0]  ITR_RST_TEST_CONTROL = 2'h0;
	localparam logic [3:0]  ITR_RST_OUTPUT_CTRL  = 4'h0;
	localparam logic [31:0] ITR_RST_WORD         = 32'h00000000;

	// ==========================================================
	// Bus encodings
	localparam logic [1:0] ITR_HRESP_OKAY = 2'h0;
endpackage

// ===== test/itr_core_model.sv
`timescale 1ns/1ns
module itr_core_model
	import itr_pkg::*;
(
	// Clock
	input wire logic        sys_clk,
	// Levels chosen by the bench
	input wire logic [3:0]  level,
	input wire logic [31:0] vec,
	// Core outputs
	output logic            request_internal,
	output logic            fast_request_internal,
	output logic            core_vector_valid,
	output logic            core_ack_forward,
	output logic [31:0]     core_vector_out
);
	// Core shares the bus clock, so its outputs move just after an edge
	always_ff @(posedge sys_clk)
	begin
		{core_ack_forward, core_vector_valid, request_internal, fast_request_internal} <= level;
		core_vector_out <= vec;
	end
endmodule

// ===== test/itr_regs_props.sv
`timescale 1ns/1ns
module itr_regs_props
	import itr_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset_n,
	// Bus
	input wire logic        hsel,
	input wire logic [11:2] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hreadyin,
	input wire logic        hreadyout,
	input wire logic [1:0]  hresp,
	input wire logic [31:0] hrdata,
	// Core side and pins
	input wire logic        request_internal,
	input wire logic        fast_request_internal,
	input wire logic        core_vector_valid,
	input wire logic        core_ack_forward,
	input wire logic [31:0] core_vector_out,
	input wire logic [31:0] chain_vector_out,
	input wire logic        request_out_n,
	input wire logic        fast_request_out_n,
	input wire logic        vector_valid_out,
	input wire logic        ack_forward_out,
	input wire logic        test_enable,
	input wire logic        sampling_enable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic rd_taken;
	logic live;
	assign rd_taken = hsel && htrans[1] && hreadyin && !hwrite;
	// Previous edge ran with live selection, so $past is meaningful
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			live <= 1'h0;
		else
			live <= !test_enable;
	end
	chk_ready_always: assert property (hreadyout)
		else $error("wait state inserted");
	chk_resp_okay: assert property (hresp == ITR_HRESP_OKAY)
		else $error("response not okay");
	chk_req_pins: assert property (live |->
		request_out_n == !$past(request_internal) && fast_request_out_n == !$past(fast_request_internal))
		else $error("request pins not inverted live");
	chk_valid_ack: assert property (live |->
		vector_valid_out == $past(core_vector_valid) && ack_forward_out == $past(core_ack_forward))
		else $error("valid or ack pin not live");
	chk_vout_live: assert property (live |-> chain_vector_out == $past(core_vector_out))
		else $error("chain vector out not live");
	chk_status_zero: assert property (rd_taken && haddr == ITR_OFS_SAMPLED[11:2] &&
		!sampling_enable |=> hrdata == ITR_RST_WORD)
		else $error("status read not zero");
	chk_reserved_zero: assert property (rd_taken && haddr == ITR_OFS_OUTPUT_CTRL[11:2] |=>
		hrdata[31:10] == 22'h0 && hrdata[5:0] == 6'h0)
		else $error("reserved bits not zero");
	chk_modes_reset: assert property ($rose(reset_n) |-> !test_enable && !sampling_enable)
		else $error("mode bits not zero after reset");
endmodule
bind itr_regs itr_regs_props u_props (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyin(hreadyin),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .request_internal(request_internal),
	.fast_request_internal(fast_request_internal), .core_vector_valid(core_vector_valid),
	.core_ack_forward(core_ack_forward), .core_vector_out(core_vector_out),
	.chain_vector_out(chain_vector_out), .request_out_n(request_out_n),
	.fast_request_out_n(fast_request_out_n), .vector_valid_out(vector_valid_out),
	.ack_forward_out(ack_forward_out), .test_enable(test_enable),
	.sampling_enable(sampling_enable));

// ===== test/test_irq_ctrl_integration_test_regs.sv
`timescale 1ns/1ns
module test_irq_ctrl_integration_test_regs;
	import itr_pkg::*;
	// ====
	// Stimulus and wires
	logic sys_clk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [11:2] haddr = 10'h0;
	logic [1:0] htrans = 2'h0, hresp;
	logic [31:0] hwdata = 32'h0, hrdata, raw_source = 32'h0, chain_vector_in = 32'h0;
	logic [31:0] vec = 32'h0, core_vec, to_core, vout;
	logic [3:0] level = 4'h0;
	logic req, fiq, cvalid, cack, hreadyout, req_n, fiq_n, valid, ack, ten, sen;
	int failures = 0, checks = 0;
	always #2 sys_clk = ~sys_clk;
	itr_core_model core (.sys_clk(sys_clk), .level(level), .vec(vec), .request_internal(req),
		.fast_request_internal(fiq), .core_vector_valid(cvalid), .core_ack_forward(cack),
		.core_vector_out(core_vec));
	itr_regs dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'h1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hprot(4'h2),
		.hwdata(hwdata), .hreadyin(1'h1), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.request_internal(req), .fast_request_internal(fiq), .core_vector_valid(cvalid),
		.core_ack_forward(cack), .core_vector_out(core_vec), .raw_source(raw_source),
		.chain_vector_in(chain_vector_in), .chain_vector_to_core(to_core),
		.chain_vector_out(vout), .request_out_n(req_n), .fast_request_out_n(fiq_n),
		.vector_valid_out(valid), .ack_forward_out(ack), .test_enable(ten),
		.sampling_enable(sen));
	// ====
	// Bus and compare tasks; each starts and ends 1 ns after an edge
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		hsel = 1'h1;
		htrans = 2'h2;
		hwrite = 1'h1;
		haddr = a[11:2];
		cyc(1);
		hsel = 1'h0;
		htrans = 2'h0;
		hwdata = d;
		cyc(1);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string name);
		hsel = 1'h1;
		htrans = 2'h2;
		hwrite = 1'h0;
		haddr = a[11:2];
		cyc(1);
		hsel = 1'h0;
		htrans = 2'h0;
		chk(name, hrdata, exp);
	endtask
	// ====
	// Scenarios
	task automatic t_reset();
		rchk(ITR_OFS_TEST_CONTROL, 32'h0, "control");
		rchk(ITR_OFS_SAMPLED, 32'h0, "status");
		rchk(12'h3FC, 32'h0, "unmapped");
		$display("reset test done");
	endtask
	task automatic t_vin();
		chain_vector_in = 32'hA5A50F0F;
		cyc(3);
		rchk(ITR_OFS_VECTOR_INPUT, 32'hA5A50F0F, "vin live");
		wr(ITR_OFS_VECTOR_INPUT, 32'h87654321);
		chk("to_core live", to_core, 32'hA5A50F0F);
		wr(ITR_OFS_TEST_CONTROL, 32'h1);
		chk("test_enable", {31'h0, ten}, 32'h1);
		rchk(ITR_OFS_VECTOR_INPUT, 32'h0, "vin refused");
		wr(ITR_OFS_VECTOR_INPUT, 32'h12345678);
		cyc(1);
		chk("to_core test", to_core, 32'h12345678);
		rchk(ITR_OFS_VECTOR_INPUT, 32'h12345678, "vin test");
		$display("vector input test done");
	endtask
	task automatic t_outctl();
		logic [31:0] old;
		logic [31:0] v;
		wr(ITR_OFS_TEST_CONTROL, 32'h0);
		level = 4'hA;
		cyc(4);
		rchk(ITR_OFS_OUTPUT_CTRL, 32'h280, "outctl live");
		wr(ITR_OFS_TEST_CONTROL, 32'h1);
		cyc(3);
		old = 32'h0;
		for (int i = 0; i < 2; i++)
		begin
			v = i ? 32'h280 : 32'h140;
			wr(ITR_OFS_OUTPUT_CTRL, v);
			rchk(ITR_OFS_OUTPUT_CTRL, old, "outctl old");
			// Read data register adds one cycle behind the two flops
			cyc(1);
			rchk(ITR_OFS_OUTPUT_CTRL, v, "outctl new");
			chk("pins", {28'h0, ack, valid, !req_n, !fiq_n}, {28'h0, v[9:6]});
			old = v;
		end
		$display("output control test done");
	endtask
	task automatic t_vout();
		vec = 32'h0F0F3C3C;
		wr(ITR_OFS_VECTOR_OUTPUT, 32'h5A5AC3C3);
		cyc(1);
		chk("vout test", vout, 32'h5A5AC3C3);
		rchk(ITR_OFS_VECTOR_OUTPUT, 32'h5A5AC3C3, "vout read");
		wr(ITR_OFS_TEST_CONTROL, 32'h0);
		cyc(2);
		rchk(ITR_OFS_VECTOR_OUTPUT, 32'h0F0F3C3C, "vout live");
		chk("vout pin", vout, 32'h0F0F3C3C);
		$display("vector output test done");
	endtask
	task automatic t_sample();
		wr(ITR_OFS_TEST_CONTROL, 32'h2);
		chk("sampling_enable", {31'h0, sen}, 32'h1);
		raw_source = 32'h80000001;
		cyc(3);
		raw_source = 32'h2;
		cyc(4);
		rchk(ITR_OFS_SAMPLED, 32'h80000003, "latched");
		wr(ITR_OFS_SAMPLED_CLEAR, 32'h3);
		rchk(ITR_OFS_SAMPLED, 32'h80000002, "clear vs set");
		raw_source = 32'h0;
		cyc(3);
		wr(ITR_OFS_SAMPLED_CLEAR, 32'h2);
		rchk(ITR_OFS_SAMPLED, 32'h80000000, "cleared");
		wr(ITR_OFS_TEST_CONTROL, 32'h0);
		rchk(ITR_OFS_SAMPLED, 32'h0, "sampling off");
		wr(ITR_OFS_SAMPLED_CLEAR, 32'hFFFFFFFF);
		wr(ITR_OFS_TEST_CONTROL, 32'h2);
		rchk(ITR_OFS_SAMPLED, 32'h80000000, "clear ignored");
		$display("sampling test done");
	endtask
	// ====
	// Verdict
	task automatic final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#40000;
		failures++;
		final_report();
	end
	initial
	begin
		cyc(2);
		reset_n = 1'h1;
		t_reset();
		t_vin();
		t_outctl();
		t_vout();
		t_sample();
		final_report();
	end
endmodule
